/* phy_irq_status.v */
/*
 * interrupt flags, interrupt mask, interrupt output and the special
 * control/status register of the management register space.
 * assumes the status inputs come from other register blocks on the same
 * clock, except line energy which arrives from the analog squelch.
 * register access is a simple read/write strobe port with a 5-bit index;
 * read data is registered and valid the cycle after the read strobe.
 */
`timescale 1ns/1ps
`include "phy_irq_defs.vh"

module phy_irq_status #(
    parameter TICK_CYCLES = `TICK_CYCLES_DEF
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    // register access port
    input wire [4:0] reg_addr_i,
    input wire reg_rd_i,
    input wire reg_wr_i,
    input wire [15:0] reg_wdata_i,
    output reg [15:0] reg_rdata_o,
    // asynchronous energy detect from the line receiver
    input wire line_energy_present_i,
    // status levels from the other register blocks
    input wire autoneg_complete_i,
    input wire remote_fault_i,
    input wire link_status_i,
    input wire partner_ack_i,
    input wire parallel_detect_fault_i,
    input wire page_received_i,
    input wire [2:0] resolved_speed_duplex_i,
    // one-cycle events from the other register blocks
    input wire basic_status_read_i,
    input wire expansion_read_i,
    input wire renegotiate_i,
    // interrupt mode select held in the mode control register
    input wire alternate_irq_select_i,
    // outputs
    output reg irq_out_low_o,
    output reg [2:0] general_outputs_o,
    output reg enc_4b5b_enable_o,
    output reg scramble_disable_o,
    output reg line_energy_status_o
);

    // address compare shared by the read and write decode
    function hit;
        input [4:0] addr;
        input [4:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    reg energy_s1_r;
    reg energy_s2_r;
    reg [6:0] flag_r;
    reg [6:0] flag_nxt;
    reg [6:0] mask_r;
    reg armed_r;
    reg armed_nxt;
    reg [8:0] pulse_cnt_r;
    reg [8:0] pulse_cnt_nxt;
    reg irq_any;
    reg [6:0] clr;
    reg [6:0] primary_clr;
    reg [6:0] alt_clr;
    reg [15:0] rdata_mux;
    wire [6:0] levels;
    wire [6:0] src_active;
    wire [6:0] ev_assert;
    wire [6:0] ev_release;
    wire ms_tick;
    wire rd_flags;
    wire wr_flags;
    wire wr_mask;
    wire wr_special;
    wire link_down;

    // energy detect is an analog-side level: two flops before use.
    // both reset to 1 so the status starts as present.
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            energy_s1_r <= 1'b1;
            energy_s2_r <= 1'b1;
        end else begin
            energy_s1_r <= line_energy_present_i;
            energy_s2_r <= energy_s1_r;
        end
    end

    // source levels ordered as flag bits 7 down to 1
    assign levels = {energy_s2_r, autoneg_complete_i, remote_fault_i,
                     link_status_i, partner_ack_i, parallel_detect_fault_i,
                     page_received_i};

    // a source is in its interrupting state when high, link when low
    assign src_active = levels ^ `FALL_SOURCES;

    level_edge_detect #(
        .RESET_LEVEL(`RST_LEVELS),
        .FALL_MASK(`FALL_SOURCES)
    ) u_edges (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .level_i(levels),
        .assert_o(ev_assert),
        .release_o(ev_release)
    );

    ms_tick_divider #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .tick_o(ms_tick)
    );

    // register access decode
    assign rd_flags = reg_rd_i & hit(reg_addr_i, `ADDR_FLAGS);
    assign wr_flags = reg_wr_i & hit(reg_addr_i, `ADDR_FLAGS);
    assign wr_mask = reg_wr_i & hit(reg_addr_i, `ADDR_MASK);
    assign wr_special = reg_wr_i & hit(reg_addr_i, `ADDR_SPECIAL);
    assign link_down = ev_assert[`IDX_LINK];

    // primary mode deassert events per source
    always @* begin
        // opposite edge clears, except link whose release edge is masked off
        primary_clr = ev_release & ~`FALL_SOURCES;
        // every flag clears on a read of the flag register
        primary_clr = primary_clr | {7{rd_flags}};
        primary_clr[`IDX_RFAULT] = primary_clr[`IDX_RFAULT]
                                   | basic_status_read_i;
        primary_clr[`IDX_LINK] = primary_clr[`IDX_LINK]
                                 | basic_status_read_i;
        primary_clr[`IDX_PDF] = primary_clr[`IDX_PDF] | expansion_read_i
                                | renegotiate_i | link_down;
        primary_clr[`IDX_PAGE] = primary_clr[`IDX_PAGE] | expansion_read_i
                                 | renegotiate_i | link_down;
    end

    // alternate mode: writing 1 clears only once the source has gone
    // inactive, otherwise the flag stays set
    always @* begin
        alt_clr = {7{wr_flags}} & reg_wdata_i[`SRC_HI:`SRC_LO] & ~src_active;
    end

    // flags latch high; a new event in the clearing cycle wins
    always @* begin
        clr = alternate_irq_select_i ? alt_clr : primary_clr;
        flag_nxt = ev_assert | (flag_r & ~clr);
    end

    // late energy pulse: armed when the energy flag is cleared by a read
    // while energy is still present and its source is enabled; the pulse
    // fires when energy later drops. limitation: only primary mode arms.
    always @* begin
        armed_nxt = armed_r;
        pulse_cnt_nxt = pulse_cnt_r;
        if (!alternate_irq_select_i && rd_flags && energy_s2_r
                && mask_r[`IDX_ENERGY] && flag_r[`IDX_ENERGY]) begin
            armed_nxt = 1'b1;
        end
        if (!mask_r[`IDX_ENERGY]) begin
            // clearing the mask disarms, as the service routine should do
            armed_nxt = 1'b0;
        end
        if (armed_r && ev_release[`IDX_ENERGY]) begin
            armed_nxt = 1'b0;
            pulse_cnt_nxt = `ENERGY_PULSE_MS;
        end else if (ms_tick && pulse_cnt_r != 9'h000) begin
            pulse_cnt_nxt = pulse_cnt_r - 9'h001;
        end
    end

    // interrupt request from enabled flags or the late energy pulse
    always @* begin
        irq_any = (|(flag_nxt & mask_r)) | (pulse_cnt_nxt != 9'h000);
    end

    // flag, pulse and interrupt output state
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            flag_r <= `RST_FLAGS;
            armed_r <= 1'b0;
            pulse_cnt_r <= 9'h000;
            irq_out_low_o <= 1'b1;
            line_energy_status_o <= 1'b1;
        end else begin
            flag_r <= flag_nxt;
            armed_r <= armed_nxt;
            pulse_cnt_r <= pulse_cnt_nxt;
            // registered, so it follows the event by one clock
            irq_out_low_o <= ~irq_any;
            line_energy_status_o <= energy_s2_r;
        end
    end

    // mask register: bits 7..1 writable, the rest not stored
    always @(posedge ref_clk_i) begin
        if (!rst_n_i)
            mask_r <= `RST_MASK;
        else if (wr_mask)
            mask_r <= reg_wdata_i[`SRC_HI:`SRC_LO];
    end

    // special control fields; reserved bits are not stored
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            general_outputs_o <= `RST_GPO;
            enc_4b5b_enable_o <= `RST_ENC;
            scramble_disable_o <= `RST_SCR;
        end else if (wr_special) begin
            general_outputs_o <= reg_wdata_i[`SPC_GPO_HI:`SPC_GPO_LO];
            enc_4b5b_enable_o <= reg_wdata_i[`SPC_ENC];
            scramble_disable_o <= reg_wdata_i[`SPC_SCR];
        end
    end

    // read mux; the flag value returned is the one before the clear.
    // the test register reads zero and accepts no write
    always @* begin
        rdata_mux = 16'h0000;
        case (reg_addr_i)
            `ADDR_FLAGS: begin
                rdata_mux[`SRC_HI:`SRC_LO] = flag_r;
            end
            `ADDR_MASK: begin
                rdata_mux[`SRC_HI:`SRC_LO] = mask_r;
            end
            `ADDR_SPECIAL: begin
                rdata_mux[`SPC_AUTODONE] = autoneg_complete_i;
                rdata_mux[`SPC_GPO_HI:`SPC_GPO_LO] = general_outputs_o;
                rdata_mux[`SPC_ENC] = enc_4b5b_enable_o;
                rdata_mux[`SPC_SPD_HI:`SPC_SPD_LO] = resolved_speed_duplex_i;
                rdata_mux[`SPC_SCR] = scramble_disable_o;
            end
            default: begin
                rdata_mux = 16'h0000;
            end
        endcase
    end

    // read data is captured on the strobe and held until the next read
    always @(posedge ref_clk_i) begin
        if (!rst_n_i)
            reg_rdata_o <= 16'h0000;
        else if (reg_rd_i)
            reg_rdata_o <= rdata_mux;
    end

endmodule

/* phy_irq_defs.vh */
/*
 * constants for the interrupt and special status block: register
 * addresses, field positions, reset values and timing counts.
 * assumes it is included once per file by its bare name.
 */
`ifndef PHY_IRQ_DEFS_VH
`define PHY_IRQ_DEFS_VH

// management register addresses (5-bit register index)
`define ADDR_TEST 5'h1c
`define ADDR_FLAGS 5'h1d
`define ADDR_MASK 5'h1e
`define ADDR_SPECIAL 5'h1f

// flag and mask fields occupy bits 7..1; internal vectors use index 0..6
`define SRC_HI 7
`define SRC_LO 1
`define IDX_ENERGY 6
`define IDX_RFAULT 4
`define IDX_LINK 3
`define IDX_PDF 1
`define IDX_PAGE 0

// special control/status fields
`define SPC_AUTODONE 12
`define SPC_GPO_HI 9
`define SPC_GPO_LO 7
`define SPC_ENC 6
`define SPC_SPD_HI 4
`define SPC_SPD_LO 2
`define SPC_SCR 0

// reset values
`define RST_MASK 7'h00
`define RST_FLAGS 7'h40
`define RST_LEVELS 7'h40
`define RST_GPO 3'h0
`define RST_ENC 1'b1
`define RST_SCR 1'b0
`define FALL_SOURCES 7'h08

// timing
`define CLK_HZ 50000000
`define MS_PER_S 1000
`define TICK_CYCLES_DEF (`CLK_HZ / `MS_PER_S)
`define ENERGY_PULSE_MS 9'h100

`endif

/* ms_tick_divider.v */
/*
 * divider that turns the system clock into a one-cycle pulse per
 * millisecond. assumes a single clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module ms_tick_divider #(
    parameter CYCLES = 50000
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    output reg tick_o
);
    reg [15:0] cnt_r;

    // count down, pulse on wrap; cycles beyond 65536 are not supported
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cnt_r <= 16'h0000;
            tick_o <= 1'b0;
        end else if (cnt_r == 16'h0000) begin
            cnt_r <= CYCLES[15:0] - 16'h0001;
            tick_o <= 1'b1;
        end else begin
            cnt_r <= cnt_r - 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule

/* level_edge_detect.v */
/*
 * per-bit edge detector for the interrupt sources. a bit flagged in
 * FALL_MASK asserts on its falling edge, the others on their rising edge.
 * assumes inputs are already in the clock domain.
 */
`timescale 1ns/1ps
module level_edge_detect #(
    parameter [6:0] RESET_LEVEL = 7'h00,
    parameter [6:0] FALL_MASK = 7'h00
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire [6:0] level_i,
    output wire [6:0] assert_o,
    output wire [6:0] release_o
);
    reg [6:0] prev_r;

    // remember last level; reset level avoids a false edge after reset
    always @(posedge ref_clk_i) begin
        if (!rst_n_i)
            prev_r <= RESET_LEVEL;
        else
            prev_r <= level_i;
    end

    genvar i;
    generate
        for (i = 0; i < 7; i = i + 1) begin : g_edge
            wire rise = level_i[i] & ~prev_r[i];
            wire fall = ~level_i[i] & prev_r[i];
            assign assert_o[i] = FALL_MASK[i] ? fall : rise;
            assign release_o[i] = FALL_MASK[i] ? rise : fall;
        end
    endgenerate
endmodule

/* irq_props_properties.sv */
/* concurrent checks on the interrupt and special status ports.
   assumes one clock, synchronous active-low reset, primary mode. */
`timescale 1ns/1ps
`include "phy_irq_defs.vh"
module irq_props (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire [4:0] reg_addr_i,
    input wire reg_rd_i,
    input wire reg_wr_i,
    input wire [15:0] reg_wdata_i,
    input wire [15:0] reg_rdata_o,
    input wire autoneg_complete_i,
    input wire link_status_i,
    input wire [2:0] resolved_speed_duplex_i,
    input wire alternate_irq_select_i,
    input wire irq_out_low_o,
    input wire [2:0] general_outputs_o,
    input wire enc_4b5b_enable_o,
    input wire scramble_disable_o
);
    reg [15:0] mask_r;
    reg [15:0] wd_r;
    // shadow mask, since the real one is not visible at the ports
    always @(posedge ref_clk_i) begin
        wd_r <= reg_wdata_i;
        if (!rst_n_i)
            mask_r <= 16'h0000;
        else if (reg_wr_i && reg_addr_i == `ADDR_MASK)
            mask_r <= reg_wdata_i & 16'h00fe;
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_rd(logic [4:0] a);
        reg_rd_i && reg_addr_i == a;
    endsequence
    sequence s_wr_spc;
        reg_wr_i && reg_addr_i == `ADDR_SPECIAL;
    endsequence
    a_mask_rsvd_zero: assert property (s_rd(`ADDR_MASK) |=>
        reg_rdata_o[15:8] == 8'h00 && !reg_rdata_o[0]) else $error("mask reserved bits set");
    a_flag_rsvd_zero: assert property (s_rd(`ADDR_FLAGS) |=>
        reg_rdata_o[15:8] == 8'h00 && !reg_rdata_o[0]) else $error("flag reserved bits set");
    a_autodone_copy: assert property (s_rd(`ADDR_SPECIAL) |=>
        reg_rdata_o[12] == $past(autoneg_complete_i)) else $error("autodone mismatch");
    a_speed_copy: assert property (s_rd(`ADDR_SPECIAL) |=>
        reg_rdata_o[4:2] == $past(resolved_speed_duplex_i)) else $error("speed mismatch");
    a_gpo_follow: assert property (s_wr_spc |=>
        general_outputs_o == wd_r[9:7]) else $error("gpo not written");
    a_coding_follow: assert property (s_wr_spc |=>
        enc_4b5b_enable_o == wd_r[6] && scramble_disable_o == wd_r[0]) else $error("coding bits");
    a_reset_idle: assert property ($rose(rst_n_i) |-> irq_out_low_o &&
        general_outputs_o == 3'h0 && enc_4b5b_enable_o && !scramble_disable_o)
        else $error("reset values wrong");
    a_autoneg_irq: assert property ($rose(autoneg_complete_i) && mask_r[6] &&
        !alternate_irq_select_i |=> !irq_out_low_o) else $error("autoneg irq missing");
    a_link_irq: assert property ($fell(link_status_i) && mask_r[4] &&
        !alternate_irq_select_i |=> !irq_out_low_o) else $error("link irq missing");
    a_read_release: assert property (s_rd(`ADDR_FLAGS) && mask_r == 16'h0040 &&
        $stable(autoneg_complete_i) |=> irq_out_low_o) else $error("read kept irq");
    a_masked_quiet: assert property (mask_r == 16'h0000 [*3] |-> irq_out_low_o)
        else $error("irq with mask clear");
endmodule
bind phy_irq_status irq_props u_props (.*);

/* mgmt_host.sv */
/* management host model on the register strobe port.
   assumes the caller waits out reset before the first access. */
`timescale 1ns/1ps
module mgmt_host (
    input wire ref_clk_i,
    input wire [15:0] reg_rdata_i,
    output reg [4:0] reg_addr_o = 5'h00,
    output reg reg_rd_o = 1'b0,
    output reg reg_wr_o = 1'b0,
    output reg [15:0] reg_wdata_o = 16'h0000
);
    // never aimed at the test register; data inverted once released
    task wr(input [4:0] a, input [15:0] d);
        begin
            @(posedge ref_clk_i);
            reg_addr_o <= a;
            reg_wr_o <= 1'b1;
            reg_wdata_o <= d;
            @(posedge ref_clk_i);
            reg_wr_o <= 1'b0;
            reg_wdata_o <= ~d;
        end
    endtask
    // answer is registered, so it is taken one edge after the strobe
    task rd(input [4:0] a, output [15:0] d);
        begin
            @(posedge ref_clk_i);
            reg_addr_o <= a;
            reg_rd_o <= 1'b1;
            @(posedge ref_clk_i);
            reg_rd_o <= 1'b0;
            @(posedge ref_clk_i);
            d = reg_rdata_i;
        end
    endtask
endmodule

/* testbench.sv */
/* self-checking bench for the interrupt and special status block.
   assumes the host model drives every register access. */
`timescale 1ns/1ps
`include "phy_irq_defs.vh"
module testbench;
    localparam TK = 4;
    reg ref_clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg [6:0] lv = 7'h08; // energy..page levels, link up
    reg [2:0] spd = 3'h5;
    reg brd = 1'b0;
    reg xrd = 1'b0;
    reg rng = 1'b0;
    reg alt = 1'b0; // host keeps primary mode after reset
    wire [4:0] addr;
    wire rd, wr;
    wire [15:0] wd, rdata;
    wire irq_n, enc, scr, en_st;
    wire [2:0] gpo;
    integer num_errors = 0, num_checks = 0, i, n;
    reg [31:0] seed = 32'h74d9;
    reg [15:0] d, m;
    mgmt_host host (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
        .reg_rd_o(rd), .reg_wr_o(wr), .reg_wdata_o(wd));
    phy_irq_status #(.TICK_CYCLES(TK)) dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wd),
        .reg_rdata_o(rdata), .line_energy_present_i(lv[6]), .autoneg_complete_i(lv[5]),
        .remote_fault_i(lv[4]), .link_status_i(lv[3]), .partner_ack_i(lv[2]),
        .parallel_detect_fault_i(lv[1]), .page_received_i(lv[0]),
        .resolved_speed_duplex_i(spd), .basic_status_read_i(brd), .expansion_read_i(xrd),
        .renegotiate_i(rng), .alternate_irq_select_i(alt), .irq_out_low_o(irq_n),
        .general_outputs_o(gpo), .enc_4b5b_enable_o(enc), .scramble_disable_o(scr),
        .line_energy_status_o(en_st));
    initial forever #10 ref_clk_i = ~ref_clk_i;
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task chk(input string nm, input [15:0] e, input [15:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("wrong value %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d errors %0d", num_checks, num_errors);
            if (num_errors == 0 && num_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // a hang is cut well past the pulse length
    initial begin
        #200000;
        num_errors = num_errors + 1;
        wrap_up;
    end
    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        host.rd(`ADDR_FLAGS, d);
        chk("flags0", 16'h0080, d);
        // status register is loaded at this edge; look once it has settled
        @(negedge ref_clk_i);
        chk("energy", 0, en_st);
        host.wr(`ADDR_FLAGS, 16'h00fe);
        host.rd(`ADDR_FLAGS, d);
        chk("flags ro", 0, d);
        // random control words, special reserved bits written as zero, mask reserved bits left random
        for (i = 0; i < 3; i = i + 1) begin
            seed = xs(seed);
            spd <= seed[2:0];
            m = seed[31:16] & 16'h03c1;
            host.wr(`ADDR_SPECIAL, m);
            host.wr(`ADDR_MASK, seed[15:0]);
            host.rd(`ADDR_MASK, d);
            chk("mask", seed[15:0] & 16'h00fe, d);
            chk("gpo", m[9:7], gpo);
            chk("coding", {m[6], m[0]}, {enc, scr});
            host.rd(`ADDR_SPECIAL, d);
            chk("special", m | {11'h0, spd, 2'b0}, d & 16'h13dd);
        end
        host.wr(`ADDR_MASK, 16'h0000);
        // each source: masked event, then unmask, read clears
        for (i = 0; i < 7; i = i + 1) begin
            @(posedge ref_clk_i) lv[i] <= ~lv[i];
            repeat (5) @(posedge ref_clk_i);
            chk("irq masked", 1, irq_n);
            host.wr(`ADDR_MASK, 16'h0002 << i);
            repeat (2) @(posedge ref_clk_i);
            chk("irq", 0, irq_n);
            host.rd(`ADDR_FLAGS, d);
            chk("flags", 16'h0002 << i, d);
            chk("irq clr", 1, irq_n);
            host.wr(`ADDR_MASK, 16'h0000);
            @(posedge ref_clk_i) lv[i] <= ~lv[i];
            repeat (5) @(posedge ref_clk_i);
        end
        // fall, basic read and expansion read release the output
        host.wr(`ADDR_MASK, 16'h0066);
        @(posedge ref_clk_i) lv[5:4] <= 2'b11;
        lv[1:0] <= 2'b11;
        repeat (3) @(posedge ref_clk_i);
        chk("irq set", 0, irq_n);
        @(posedge ref_clk_i) lv[5] <= 1'b0;
        brd <= 1'b1;
        xrd <= 1'b1;
        @(posedge ref_clk_i) brd <= 1'b0;
        xrd <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        chk("irq rel", 1, irq_n);
        lv[4] <= 1'b0;
        lv[1:0] <= 2'b00;
        // renegotiation alone releases the fault and page flags
        host.wr(`ADDR_MASK, 16'h0006);
        @(posedge ref_clk_i) lv[1:0] <= 2'b11;
        repeat (3) @(posedge ref_clk_i);
        chk("irq pdf", 0, irq_n);
        @(posedge ref_clk_i) rng <= 1'b1;
        @(posedge ref_clk_i) rng <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        chk("irq reneg", 1, irq_n);
        lv[1:0] <= 2'b00;
        // late energy pulse after a read while energy stays up
        host.wr(`ADDR_MASK, 16'h0080);
        @(posedge ref_clk_i) lv[6] <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        host.rd(`ADDR_FLAGS, d);
        chk("irq energy", 1, irq_n);
        @(posedge ref_clk_i) lv[6] <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        chk("pulse on", 0, irq_n);
        n = 0;
        while (irq_n === 1'b0 && n < 2000) begin
            @(posedge ref_clk_i);
            n = n + 1;
        end
        chk("pulse len", 1, n >= 256 * TK - 12 && n <= 257 * TK + 2);
        // alternate mode: a write of 1 clears only once the source is gone
        host.wr(`ADDR_MASK, 16'h0040);
        alt <= 1'b1;
        @(posedge ref_clk_i) lv[5] <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        chk("alt set", 0, irq_n);
        host.wr(`ADDR_FLAGS, 16'h0040);
        repeat (2) @(posedge ref_clk_i);
        chk("alt hold", 0, irq_n);
        @(posedge ref_clk_i) lv[5] <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        chk("alt fall", 0, irq_n);
        host.wr(`ADDR_FLAGS, 16'h0040);
        repeat (2) @(posedge ref_clk_i);
        chk("alt clr", 1, irq_n);
        alt <= 1'b0;
        host.wr(`ADDR_MASK, 16'h0000);
        wrap_up;
    end
endmodule
